// ===== eirq_ctrl.sv
// External interrupt pin logic, supply detector interrupt/warning and reset cause record.
// Assumes an APB master on pclk, a reset controller that holds the cause levels
// steady across the release of presetn, and a separate power-on reset por_n.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Low supply with detector, its interrupt on and reset off sets flag, interrupts.
// - Warning flag shows supply nearing the trip level and never interrupts.
// - One control bit picks the high or the low warning trip level.
// - Pin control bit 6 low keeps the pull device on while bit 4 enables the pin, high turns it off.
// - Bit 5 low selects falling/low sensing, high selects rising/high sensing.
// - With pin enabled and rising polarity the pull-up becomes a pull-down.
// - Bit 4 enables the pin as an interrupt source; clear means pin ignored.
// - Bit 3 reads the event flag, set after a qualifying pin event.
// - Bit 2 is acknowledge: write 1 clears the flag, reads zero.
// - In edge-and-level mode acknowledge cannot clear while pin stays asserted.
// - Bit 1 lets the event flag raise the interrupt; otherwise software polls.
// - Bit 0 low detects edges only, high detects edges plus level.
// - Reset cause register holds six read-only flags for the last reset.
// - A debug forced reset leaves every cause flag cleared.
// - Any write to the reset cause address refreshes the watchdog only.
// - Power-on sets bit 7 together with the low supply reset flag.
// - Bit 6 marks a reset from the external reset pin.
// - Bit 5 marks a watchdog reset, impossible while the watchdog is off.
// - Bit 4 marks bad opcodes, including disallowed stop and background instructions.
// - Bit 2 marks a clock loss reset; bit 3 always reads zero.
// - Bit 1 marks a low supply reset or a power-on reset.
// - Power-on gives 82h; low supply keeps bit 7; others clear bits 7, 1.
// - Only the debug path may force a reset; bus writes there are ignored.
module eirq_ctrl (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // System reset, active low
    input wire logic por_n, // Power-on reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [eirq_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic irq_pin_in, // Interrupt request pin level
    output logic pin_pull_on, // Pull device active on the pin
    output logic pin_pull_down, // Pull device acts as pull-down
    output logic pin_irq, // Pin interrupt request
    input wire logic supply_below_trip, // Detector comparator, asynchronous
    input wire logic supply_below_warn_high, // High warning comparator, asynchronous
    input wire logic supply_below_warn_low, // Low warning comparator, asynchronous
    output logic supply_irq, // Supply detector interrupt request
    output logic low_supply_reset, // Low supply reset request, level
    output logic supply_detector_stop_enable, // Detector kept on in stop
    input wire logic cause_power_on, // Reset controller: power-on
    input wire logic cause_low_supply, // Reset controller: low supply
    input wire logic cause_pin, // Reset controller: reset pin
    input wire logic cause_watchdog, // Reset controller: watchdog timeout
    input wire logic cause_bad_opcode, // Reset controller: bad opcode
    input wire logic cause_stop_attempt, // Reset controller: stop executed
    input wire logic cause_bgnd_attempt, // Reset controller: background executed
    input wire logic cause_clock_loss, // Reset controller: clock loss
    input wire logic cause_debug, // Reset controller: debug forced
    input wire logic watchdog_enable, // Watchdog enable option
    input wire logic stop_allow, // Stop instruction allowed
    input wire logic background_mode_allow, // Background instruction allowed
    output logic watchdog_refresh, // One-cycle watchdog restart
    input wire logic dbg_write, // Debug path write strobe to force-reset
    input wire logic [7:0] dbg_wdata, // Debug path write data
    output logic debug_forced_reset // One-cycle whole-chip reset request
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic pull_disable;
        logic polarity;
        logic func_enable;
        logic event_flag;
        logic int_enable;
        logic detect_mode;
        logic [eirq_pkg::SY_LANES-1:0] sync1;
        logic [eirq_pkg::SY_LANES-1:0] sync2;
        logic prev_asserted;
        logic sd_enable;
        logic sd_int_enable;
        logic sd_reset_enable;
        logic sd_stop_enable;
        logic warn_level;
        logic detect_flag;
        logic warning;
        logic low_reset;
        logic captured;
        logic [31:0] rdata;
        logic wd_refresh;
        logic dbg_reset;
    } eirq_state_s;

    eirq_state_s state;
    eirq_state_s next_state;
    logic [7:0] cause;
    logic [7:0] next_cause;

    // Decoded bus phases, pin events, trip level and bad opcode
    logic setup_phase;
    logic wr_access;
    logic mapped;
    logic pin_level;
    logic pin_asserted;
    logic pin_edge;
    logic pin_hold;
    logic below_trip;
    logic bad_opcode;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Registers answer with no wait states
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign mapped = (paddr == eirq_pkg::OFS_PIN_CTRL) || (paddr == eirq_pkg::OFS_RESET_CAUSE) ||
                    (paddr == eirq_pkg::OFS_SUPPLY_CTRL) || (paddr == eirq_pkg::OFS_FORCE_RESET);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Pin event detection
    // ------------------------------------------------------------
    // synchronised sample only
    assign pin_level = state.sync2[eirq_pkg::SY_PIN];
    assign pin_asserted = state.polarity ? pin_level : !pin_level;
    assign pin_edge = pin_asserted && !state.prev_asserted;
    assign pin_hold = state.detect_mode && pin_asserted;
    assign below_trip = state.sync2[eirq_pkg::SY_BELOW_TRIP];

    assign bad_opcode = cause_bad_opcode || (cause_stop_attempt && !stop_allow) ||
                        (cause_bgnd_attempt && !background_mode_allow);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Fills the next copy of all block state but the cause record from the bus, pins and detector
    always_comb begin
        logic set_pin;
        logic set_det;
        logic [7:0] rbyte;
        next_state = state;
        set_pin = 1'b0;
        set_det = 1'b0;
        rbyte = 8'h00;

        // Two-flop synchronisers for every asynchronous input
        next_state.sync1 = {supply_below_warn_low, supply_below_warn_high, supply_below_trip, irq_pin_in};
        next_state.sync2 = state.sync1;
        next_state.prev_asserted = pin_asserted;
        next_state.wd_refresh = 1'b0;
        next_state.dbg_reset = 1'b0;
        next_state.captured = 1'b1;

        if (state.func_enable) begin
            set_pin = pin_edge || pin_hold;
        end

        if (state.sd_enable && state.sd_int_enable && !state.sd_reset_enable && below_trip) begin
            set_det = 1'b1;
        end

        // one bit picks the warning trip level
        if (state.sd_enable) begin
            next_state.warning = state.warn_level ? state.sync2[eirq_pkg::SY_WARN_HIGH]
                                                  : state.sync2[eirq_pkg::SY_WARN_LOW];
        end else begin
            next_state.warning = 1'b0;
        end

        next_state.low_reset = state.sd_enable && state.sd_reset_enable && below_trip;

        // Register writes take effect in the access phase
        if (wr_access) begin
            unique case (paddr)
                eirq_pkg::OFS_PIN_CTRL: begin
                    next_state.pull_disable = pwdata[eirq_pkg::PIN_PULL_DISABLE];
                    next_state.polarity = pwdata[eirq_pkg::PIN_POLARITY];
                    next_state.func_enable = pwdata[eirq_pkg::PIN_FUNC_ENABLE];
                    next_state.int_enable = pwdata[eirq_pkg::PIN_INT_ENABLE];
                    next_state.detect_mode = pwdata[eirq_pkg::PIN_DETECT_MODE];
                    if (pwdata[eirq_pkg::PIN_EVENT_ACK] && !pin_hold) begin
                        next_state.event_flag = 1'b0;
                    end
                end
                eirq_pkg::OFS_RESET_CAUSE: begin
                    next_state.wd_refresh = 1'b1;
                end
                eirq_pkg::OFS_SUPPLY_CTRL: begin
                    next_state.sd_enable = pwdata[eirq_pkg::SD_ENABLE];
                    next_state.sd_int_enable = pwdata[eirq_pkg::SD_INT_ENABLE];
                    next_state.sd_reset_enable = pwdata[eirq_pkg::SD_RESET_ENABLE];
                    next_state.sd_stop_enable = pwdata[eirq_pkg::SD_STOP_ENABLE];
                    next_state.warn_level = pwdata[eirq_pkg::SD_WARN_LEVEL];
                    if (pwdata[eirq_pkg::SD_DETECT_ACK]) begin
                        next_state.detect_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // New events win over a clear in the same cycle
        if (set_pin) begin
            next_state.event_flag = 1'b1;
        end
        if (set_det) begin
            next_state.detect_flag = 1'b1;
        end

        // The debug strobe lasts one cycle, so the request pulse does too
        // only the debug path forces reset
        next_state.dbg_reset = dbg_write && dbg_wdata[eirq_pkg::FR_REQUEST];

        // Read data is captured in the setup phase
        if (setup_phase && !pwrite) begin
            unique case (paddr)
                eirq_pkg::OFS_PIN_CTRL: begin
                    rbyte[eirq_pkg::PIN_PULL_DISABLE] = state.pull_disable;
                    rbyte[eirq_pkg::PIN_POLARITY] = state.polarity;
                    rbyte[eirq_pkg::PIN_FUNC_ENABLE] = state.func_enable;
                    rbyte[eirq_pkg::PIN_EVENT_FLAG] = state.event_flag;
                    rbyte[eirq_pkg::PIN_INT_ENABLE] = state.int_enable;
                    rbyte[eirq_pkg::PIN_DETECT_MODE] = state.detect_mode;
                end
                eirq_pkg::OFS_RESET_CAUSE: begin
                    rbyte = cause;
                end
                eirq_pkg::OFS_SUPPLY_CTRL: begin
                    rbyte[eirq_pkg::SD_ENABLE] = state.sd_enable;
                    rbyte[eirq_pkg::SD_INT_ENABLE] = state.sd_int_enable;
                    rbyte[eirq_pkg::SD_RESET_ENABLE] = state.sd_reset_enable;
                    rbyte[eirq_pkg::SD_STOP_ENABLE] = state.sd_stop_enable;
                    rbyte[eirq_pkg::SD_WARN_LEVEL] = state.warn_level;
                    rbyte[eirq_pkg::SD_WARNING] = state.warning;
                    rbyte[eirq_pkg::SD_DETECT_FLAG] = state.detect_flag;
                end
                default: begin
                    rbyte = 8'h00;
                end
            endcase
            next_state.rdata = {24'h000000, rbyte};
        end
    end

    // ------------------------------------------------------------
    // Reset cause capture
    // ------------------------------------------------------------
    // Records causes once, in the first cycle after system reset release
    // The levels are also sampled on every edge while presetn is low, so the
    // reset controller must hold them steady from the assertion of reset on
    always_comb begin
        next_cause = cause;
        if (!state.captured) begin
            if (cause_debug) begin
                next_cause = 8'h00;
            end else if (cause_power_on) begin
                next_cause = eirq_pkg::RC_POWER_ON_VALUE;
            end else if (cause_low_supply) begin
                // bit 7 unaffected, bit 1 set
                next_cause = 8'h00;
                next_cause[eirq_pkg::RC_POWER_ON] = cause[eirq_pkg::RC_POWER_ON];
                next_cause[eirq_pkg::RC_LOW_SUPPLY] = 1'b1;
            end else begin
                // other resets set active causes only
                next_cause = 8'h00;
                next_cause[eirq_pkg::RC_PIN] = cause_pin;
                next_cause[eirq_pkg::RC_WATCHDOG] = cause_watchdog && watchdog_enable;
                next_cause[eirq_pkg::RC_BAD_OPCODE] = bad_opcode;
                // clock loss; bit 3 stays zero
                next_cause[eirq_pkg::RC_CLOCK_LOSS] = cause_clock_loss;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All block state except the cause record, which only por_n resets, under system reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            cause <= eirq_pkg::RC_POWER_ON_VALUE;
        end else begin
            cause <= next_cause;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = state.rdata;
    // The pad applies the pull; with the pin disabled both outputs stay low
    // pull device unless disabled
    assign pin_pull_on = state.func_enable && !state.pull_disable;
    // rising polarity turns it to pull-down
    assign pin_pull_down = state.func_enable && state.polarity;
    assign pin_irq = state.int_enable && state.event_flag;
    assign supply_irq = state.sd_int_enable && state.detect_flag;
    assign low_supply_reset = state.low_reset;
    assign supply_detector_stop_enable = state.sd_stop_enable;
    assign watchdog_refresh = state.wd_refresh;
    assign debug_forced_reset = state.dbg_reset;

endmodule : eirq_ctrl

`default_nettype wire

// ===== eirq_ctrl_properties.sv
// Concurrent checks on the ports of the interrupt pin and reset cause block.
// Assumes a single pclk domain under presetn; attached by bind.
`timescale 1ns/10ps
`default_nettype none
module eirq_ctrl_props (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [eirq_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pin_irq, // Pin request
    input wire logic pin_pull_on, // Pull active
    input wire logic pin_pull_down, // Pull downward
    input wire logic supply_irq, // Supply request
    input wire logic supply_below_trip, // Trip comparator
    input wire logic watchdog_refresh, // Watchdog restart
    input wire logic dbg_write, // Debug strobe
    input wire logic [7:0] dbg_wdata, // Debug data
    input wire logic debug_forced_reset // Chip reset request
);
    logic acc;
    logic wr_pin;
    logic rd_pin;
    logic wr_rc;
    logic rd_rc;
    logic dbg_go;
    // Decoded access phases
    assign acc = psel && penable;
    assign wr_pin = acc && pwrite && paddr == eirq_pkg::OFS_PIN_CTRL;
    assign rd_pin = acc && !pwrite && paddr == eirq_pkg::OFS_PIN_CTRL;
    assign wr_rc = acc && pwrite && paddr == eirq_pkg::OFS_RESET_CAUSE;
    assign rd_rc = acc && !pwrite && paddr == eirq_pkg::OFS_RESET_CAUSE;
    assign dbg_go = dbg_write && dbg_wdata[0];
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_pull_enable: assert property (
        wr_pin |=> pin_pull_on == ($past(pwdata[4]) && !$past(pwdata[6])))
        else $error("pull enable wrong after write");
    a_pull_direction: assert property (
        wr_pin |=> pin_pull_down == ($past(pwdata[4]) && $past(pwdata[5])))
        else $error("pull direction wrong after write");
    a_irq_masked: assert property (
        wr_pin && !pwdata[1] |=> !pin_irq)
        else $error("pin request with interrupt disabled");
    a_ack_reads_zero: assert property (
        rd_pin |-> prdata[2] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("acknowledge bit read back nonzero");
    a_cause_bit_zero: assert property (
        rd_rc |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("reset cause bit 3 read nonzero");
    a_refresh_on_write: assert property (
        watchdog_refresh == $past(wr_rc))
        else $error("watchdog restart not tied to cause write");
    a_debug_pulse: assert property (
        debug_forced_reset == $past(dbg_go))
        else $error("forced reset not tied to debug write");
    a_supply_cause: assert property (
        $rose(supply_irq) |-> $past(supply_below_trip, 2))
        else $error("supply request without trip");
endmodule : eirq_ctrl_props
bind eirq_ctrl eirq_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pin_irq(pin_irq),
    .pin_pull_on(pin_pull_on), .pin_pull_down(pin_pull_down), .supply_irq(supply_irq),
    .supply_below_trip(supply_below_trip), .watchdog_refresh(watchdog_refresh), .dbg_write(dbg_write),
    .dbg_wdata(dbg_wdata), .debug_forced_reset(debug_forced_reset));
`default_nettype wire

// ===== eirq_ctrl_tb.sv
// Self-checking bench for the interrupt pin, supply detector and reset cause block.
// Assumes the pin source model and the bound property checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module eirq_ctrl_tb;
    logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [eirq_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rdat, r;
    logic pready, pslverr, rerr, pin, pull_on, pull_down, pin_irq, supply_irq, low_rst, b7, p, m, wd, sd_stop, dfr;
    logic drv_en = 1'b0, drv_val = 1'b0, trip = 1'b0, wh = 1'b0, wl = 1'b0, dbg_write = 1'b0;
    logic [11:0] cz = 12'h002; // Power-on cause at first release
    logic [7:0] dbg_wdata = 8'h00, e, c;
    int num_errors = 0, compares = 0, cyc = 0;
    localparam logic [11:0] PIN = eirq_pkg::OFS_PIN_CTRL, RC = eirq_pkg::OFS_RESET_CAUSE;
    localparam logic [11:0] SUP = eirq_pkg::OFS_SUPPLY_CTRL, FRC = eirq_pkg::OFS_FORCE_RESET;
    // Clock, 8 ns period
    always #4 pclk = ~pclk;
    eirq_ctrl DUT (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pin_in(pin), .pin_pull_on(pull_on), .pin_pull_down(pull_down),
        .pin_irq(pin_irq), .supply_below_trip(trip), .supply_below_warn_high(wh),
        .supply_below_warn_low(wl), .supply_irq(supply_irq), .low_supply_reset(low_rst),
        .supply_detector_stop_enable(sd_stop), .cause_debug(cz[0]), .cause_power_on(cz[1]),
        .cause_low_supply(cz[2]), .cause_pin(cz[3]), .cause_watchdog(cz[4]), .cause_bad_opcode(cz[5]),
        .cause_stop_attempt(cz[6]), .cause_bgnd_attempt(cz[7]), .cause_clock_loss(cz[8]),
        .watchdog_enable(cz[9]), .stop_allow(cz[10]), .background_mode_allow(cz[11]),
        .watchdog_refresh(wd), .dbg_write(dbg_write), .dbg_wdata(dbg_wdata), .debug_forced_reset(dfr));
    eirq_pin_src u_src (.pclk(pclk), .drive_en(drv_en), .drive_val(drv_val), .pull_on(pull_on),
        .pull_down(pull_down), .pin(pin));
    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h00000000);
        `CHK(rdat, {24'h000000, x})
    endtask : chk_rd
    task automatic rst(input logic por);
        @(posedge pclk);
        presetn <= 1'b0;
        por_n <= !por;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
    endtask : rst
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Expected cause byte: debug, power-on, low supply, then the rest
    function automatic logic [7:0] exp_cause(input logic [11:0] k, input logic k7);
        if (k[0]) return 8'h00;
        if (k[1]) return 8'h82;
        if (k[2]) return {k7, 7'h02};
        return {1'b0, k[3], k[4] & k[9], k[5] | (k[6] & !k[10]) | (k[7] & !k[11]), 1'b0, k[8], 2'b00};
    endfunction : exp_cause
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h05a80d0d));
        rst(1'b1);
        chk_rd(RC, 8'h82);
        b7 = 1'b1;
        for (int k = 0; k < 14; k++) begin
            r = (k == 0) ? 32'h0003F004 : $urandom;
            cz <= {r[11:3], r[2:0] & r[14:12] & r[17:15]};
            rst(1'b0);
            e = exp_cause(cz, b7);
            chk_rd(RC, e);
            apb(1'b1, RC, $urandom);
            @(posedge pclk);
            `CHK(wd, 1'b1)
            chk_rd(RC, e);
            b7 = e[7];
        end
        $display("test reset cause done");
        for (int t = 0; t < 4; t++) begin
            p = t[1];
            m = t[0];
            r = $urandom;
            c = {1'b0, r[0], p, 1'b1, 2'b00, 1'b1, m};
            drv_en <= 1'b1;
            drv_val <= !p;
            repeat (3) @(posedge pclk);
            apb(1'b1, PIN, {24'h0, c});
            apb(1'b1, PIN, {24'h0, c | 8'h04});
            `CHK({pull_on, pull_down}, {!r[0], p})
            chk_rd(PIN, c);
            drv_val <= p;
            repeat (5) @(posedge pclk);
            chk_rd(PIN, c | 8'h08);
            `CHK(pin_irq, 1'b1)
            apb(1'b1, PIN, {24'h0, c | 8'h04});
            repeat (3) @(posedge pclk);
            chk_rd(PIN, c | {4'h0, m, 3'b000});
            drv_val <= !p;
            repeat (5) @(posedge pclk);
            chk_rd(PIN, c | {4'h0, m, 3'b000});
            apb(1'b1, PIN, {24'h0, c | 8'h04});
            chk_rd(PIN, c);
        end
        apb(1'b1, PIN, 32'h00000006);
        repeat (3) @(posedge pclk);
        drv_val <= 1'b1;
        repeat (4) @(posedge pclk);
        drv_val <= 1'b0;
        repeat (4) @(posedge pclk);
        chk_rd(PIN, 8'h02);
        `CHK(pin_irq, 1'b0)
        apb(1'b1, PIN, 32'h00000000);
        $display("test pin done");
        apb(1'b1, SUP, 32'h00000003);
        trip <= 1'b1;
        repeat (5) @(posedge pclk);
        chk_rd(SUP, 8'h83);
        `CHK(supply_irq, 1'b1)
        trip <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b1, SUP, 32'h00000023);
        chk_rd(SUP, 8'h03);
        apb(1'b1, SUP, 32'h00000007);
        trip <= 1'b1;
        repeat (5) @(posedge pclk);
        chk_rd(SUP, 8'h07);
        `CHK(low_rst, 1'b1)
        trip <= 1'b0;
        wh <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, SUP, 32'(11 + 16 * v));
            repeat (4) @(posedge pclk);
            chk_rd(SUP, 8'(11 + 80 * v));
            `CHK(sd_stop, 1'b1)
            `CHK(supply_irq, 1'b0)
        end
        $display("test supply done");
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK({rerr, rdat}, 33'h100000000)
        apb(1'b1, FRC, 32'h00000001);
        chk_rd(FRC, 8'h00);
        dbg_wdata <= 8'h01;
        dbg_write <= 1'b1;
        @(posedge pclk);
        dbg_write <= 1'b0;
        @(posedge pclk);
        `CHK(dfr, 1'b1)
        $display("test bus and debug done");
        give_verdict();
    end
endmodule : eirq_ctrl_tb
`default_nettype wire

// ===== eirq_pin_src.sv
// Behavioural source on the far side of the interrupt request pin.
// Assumes the bench commands drive enable and level on pclk.
`timescale 1ns/10ps
`default_nettype none
module eirq_pin_src (
    input wire logic pclk, // Bus clock
    input wire logic drive_en, // Source drives the pin
    input wire logic drive_val, // Level driven
    input wire logic pull_on, // Device pull active
    input wire logic pull_down, // Pull acts downward
    output logic pin // Resolved pin level
);
    initial pin = 1'b1;
    // Driven level wins, then the pull; a floating pin wanders each cycle
    // pull on pin
    always @(posedge pclk) begin
        if (drive_en) begin
            pin <= drive_val;
        end else if (pull_on) begin
            pin <= !pull_down;
        end else begin
            pin <= !pin;
        end
    end
endmodule : eirq_pin_src
`default_nettype wire

// ===== eirq_pkg.sv
// Constants for the external interrupt pin, supply detector and reset cause block.
// Assumes an APB master with 32-bit data; only the low byte of each register is live.
package eirq_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_PIN_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_FORCE_RESET = 12'h00C;

    // ------------------------------------------------------------
    // Pin status/control fields
    // ------------------------------------------------------------
    localparam int PIN_PULL_DISABLE = 6;
    localparam int PIN_POLARITY = 5;
    localparam int PIN_FUNC_ENABLE = 4;
    localparam int PIN_EVENT_FLAG = 3;
    localparam int PIN_EVENT_ACK = 2;
    localparam int PIN_INT_ENABLE = 1;
    localparam int PIN_DETECT_MODE = 0;

    // ------------------------------------------------------------
    // Reset cause fields
    // ------------------------------------------------------------
    localparam int RC_POWER_ON = 7;
    localparam int RC_PIN = 6;
    localparam int RC_WATCHDOG = 5;
    localparam int RC_BAD_OPCODE = 4;
    localparam int RC_CLOCK_LOSS = 2;
    localparam int RC_LOW_SUPPLY = 1;
    localparam logic [7:0] RC_POWER_ON_VALUE = 8'h82;

    // ------------------------------------------------------------
    // Supply detector control/status fields
    // ------------------------------------------------------------
    localparam int SD_ENABLE = 0;
    localparam int SD_INT_ENABLE = 1;
    localparam int SD_RESET_ENABLE = 2;
    localparam int SD_STOP_ENABLE = 3;
    localparam int SD_WARN_LEVEL = 4;
    localparam int SD_DETECT_ACK = 5;
    localparam int SD_WARNING = 6;
    localparam int SD_DETECT_FLAG = 7;
    // Force-reset request bit, written only from the debug path
    localparam int FR_REQUEST = 0;

    // Synchroniser lanes for asynchronous inputs
    localparam int SY_PIN = 0;
    localparam int SY_BELOW_TRIP = 1;
    localparam int SY_WARN_HIGH = 2;
    localparam int SY_WARN_LOW = 3;
    localparam int SY_LANES = 4;

endpackage : eirq_pkg
